// ---- hdl/wdt_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_core
  import wdt_pkg::*;
#(
  parameter int DIV_EXP = `WDT_DIV_EXP
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cpu side
  output logic timeout_interrupt,
  output logic nmi_pending,
  output logic wdt_reset_req,
  output logic irq
);

  // bus state
  logic acc;
  logic addr_hit;
  logic wr_pend;
  logic next_wr_pend;
  logic rd_pend;
  logic next_rd_pend;
  logic [7:0] bus_addr;
  logic [7:0] next_bus_addr;
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  logic [31:0] rd_mux;
  logic wr_ctrl;
  logic wr_code;
  logic wr_istat;
  logic wr_imask;
  logic [7:0] wbyte;

  // watchdog state
  wdt_state_t state;
  wdt_state_t next_state;
  logic [1:0] bincnt;
  logic [1:0] next_bincnt;
  logic overflow_action_select;
  logic next_ovf_sel;
  logic [1:0] period_select;
  logic [1:0] next_psel;
  logic prescaler_select;
  logic next_presc;
  logic next_pending;
  logic next_timeout;
  logic tick;
  logic clr;
  logic ovf;
  logic nmi_ev;
  logic rst_start;

  // interrupt state
  logic [1:0] ist;
  logic [1:0] next_ist;
  logic [1:0] imask;
  logic [1:0] next_imask;
  logic next_irq;

  // prescaling divider, free running
  wdt_divider #(
    .DIV_EXP(DIV_EXP)
  ) u_div (
    .mclk(mclk),
    .nrst(nrst),
    .period_select(period_select),
    .prescaler_select(prescaler_select),
    .tick(tick)
  );

  // internal reset request stretcher
  wdt_rst_stretch u_rst (
    .mclk(mclk),
    .nrst(nrst),
    .start(rst_start),
    .rst_out(wdt_reset_req)
  );

  // address phase acceptance and write strobes
  assign addr_hit = (haddr[31:8] == 24'h0);
  assign acc = hsel && htrans[1] && hready;
  assign wbyte = hwdata[7:0];
  assign wr_ctrl = wr_pend && (bus_addr == `WDT_OFS_CTRL);
  assign wr_code = wr_pend && (bus_addr == `WDT_OFS_CODE);
  assign wr_istat = wr_pend && (bus_addr == `WDT_OFS_ISTAT);
  assign wr_imask = wr_pend && (bus_addr == `WDT_OFS_IMASK);

  // read data; control and code port are write-only and read zero
  always_comb
  begin
    case (bus_addr)
      `WDT_OFS_STAT:
        rd_mux = {26'h0, wdt_reset_req, nmi_pending, bincnt, state == WDT_RUN, state != WDT_OFF};
      `WDT_OFS_ISTAT:
        rd_mux = {30'h0, ist};
      `WDT_OFS_IMASK:
        rd_mux = {30'h0, imask};
      default:
        rd_mux = 32'h0;
    endcase
  end

  // bus next state: writes complete with no wait, reads take one wait cycle
  always_comb
  begin
    next_wr_pend = acc && hwrite && (hsize == `WDT_HSIZE_WORD);
    next_rd_pend = acc && !hwrite;
    next_bus_addr = bus_addr;
    if (acc)
    begin
      next_bus_addr = addr_hit ? haddr[7:0] : `WDT_OFS_NONE;
    end
    next_hreadyout = !(acc && !hwrite);
    next_hrdata = rd_pend ? rd_mux : hrdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      bus_addr <= `WDT_OFS_NONE;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      bus_addr <= next_bus_addr;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
    end
  end

  // code decode and overflow detection
  assign clr = wr_code && (wbyte == `WDT_CODE_CLEAR);
  assign ovf = tick && (bincnt == 2'h3) && (state != WDT_OFF) && !clr && !wdt_reset_req;
  assign nmi_ev = ovf && !overflow_action_select;
  assign rst_start = ovf && overflow_action_select;

  // watchdog next state
  always_comb
  begin
    next_state = state;
    next_psel = period_select;
    next_presc = prescaler_select;
    next_ovf_sel = overflow_action_select;
    next_bincnt = bincnt;
    next_pending = nmi_pending;
    if (wr_ctrl)
    begin
      next_psel = hwdata[`WDT_PSEL_HI:`WDT_PSEL_LO];
      next_presc = hwdata[`WDT_BIT_PRESC];
      next_ovf_sel = overflow_action_select & hwdata[`WDT_BIT_OVF_SEL]; // once cleared stays clear
    end
    // disable only after enable cleared and then disable code
    case (state)
      WDT_RUN:
        if (wr_ctrl && !hwdata[`WDT_BIT_EN])
        begin
          next_state = WDT_ARMED;
        end
      WDT_ARMED:
        if (wr_ctrl && hwdata[`WDT_BIT_EN])
        begin
          next_state = WDT_RUN;
        end
        else if (wr_code && (wbyte == `WDT_CODE_DISABLE))
        begin
          next_state = WDT_OFF;
        end
      WDT_OFF:
        if (wr_ctrl && hwdata[`WDT_BIT_EN])
        begin
          next_state = WDT_RUN;
        end
      default:
        next_state = WDT_RUN;
    endcase
    // binary counter: held at zero while off, zeroed by clear, other codes ignored
    if (state == WDT_OFF || clr)
    begin
      next_bincnt = 2'h0;
    end
    else if (tick)
    begin
      next_bincnt = bincnt + 2'h1;
    end
    // pending timeout: only the clear code or a watchdog reset retires it, a clear on the overflow tick suppresses the new one
    if (nmi_ev)
    begin
      next_pending = 1'b1;
    end
    else if (clr)
    begin
      next_pending = 1'b0;
    end
    // request raised on every overflow with overflow_action_select clear, no interrupt enable gating
    next_timeout = nmi_ev;
    // watchdog reset reinitialises the watchdog registers; interrupt status and mask keep their values
    if (wdt_reset_req)
    begin
      next_state = WDT_RUN;
      next_psel = `WDT_PSEL_RST;
      next_presc = `WDT_PRESC_RST;
      next_ovf_sel = `WDT_OVF_SEL_RST;
      next_bincnt = 2'h0;
      next_pending = 1'b0;
    end
  end

  // watchdog registers, enabled from reset
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state <= WDT_RUN;
      period_select <= `WDT_PSEL_RST;
      prescaler_select <= `WDT_PRESC_RST;
      overflow_action_select <= `WDT_OVF_SEL_RST;
      bincnt <= 2'h0;
      nmi_pending <= 1'b0;
      timeout_interrupt <= 1'b0;
    end
    else
    begin
      state <= next_state;
      period_select <= next_psel;
      prescaler_select <= next_presc;
      overflow_action_select <= next_ovf_sel;
      bincnt <= next_bincnt;
      nmi_pending <= next_pending;
      timeout_interrupt <= next_timeout;
    end
  end

  // sticky event bits, write one to clear, set wins
  always_comb
  begin
    next_ist = (ist & ~(wr_istat ? hwdata[1:0] : 2'h0)) | {rst_start, nmi_ev};
    next_imask = wr_imask ? hwdata[1:0] : imask;
    next_irq = |(ist & imask);
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ist <= 2'h0;
      imask <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      ist <= next_ist;
      imask <= next_imask;
      irq <= next_irq;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_enable_at_reset: assert property ($rose(nrst) |-> state == WDT_RUN && bincnt == 2'h0)
    else $error("watchdog not running after reset");

  chk_off_holds_zero: assert property (state == WDT_OFF |=> bincnt == 2'h0)
    else $error("counter moved while disabled");

  chk_clear_code: assert property (wr_code && wbyte == `WDT_CODE_CLEAR |=> bincnt == 2'h0 && !nmi_pending)
    else $error("clear code did not zero counter");

  chk_timeout_pulse: assert property (nmi_ev |=> timeout_interrupt && nmi_pending ##1 !timeout_interrupt)
    else $error("timeout interrupt not raised on overflow");

  chk_nested_timeout: assert property (nmi_ev && nmi_pending |=> timeout_interrupt)
    else $error("nested timeout not raised at once");

  chk_reset_request: assert property (rst_start |=> wdt_reset_req && !timeout_interrupt)
    else $error("reset request missing on overflow");

  chk_bad_code: assert property (wr_code && wbyte != `WDT_CODE_CLEAR && wbyte != `WDT_CODE_DISABLE
    && !tick && !wdt_reset_req |=> $stable(bincnt) && $stable(state))
    else $error("invalid code changed watchdog state");

  chk_code_reads_zero: assert property (rd_pend && bus_addr == `WDT_OFS_CODE |=> hrdata == 32'h0 && hreadyout)
    else $error("code port read returned data");

  chk_disable_order: assert property (state == WDT_RUN |=> state != WDT_OFF)
    else $error("disabled without arming first");

  cov_timeout: cover property (timeout_interrupt);
  cov_reset: cover property ($rose(wdt_reset_req));
  cov_disabled: cover property (state == WDT_ARMED ##1 state == WDT_OFF);
  cov_clear: cover property (clr && bincnt != 2'h0);

endmodule // wdt_core
`default_nettype wire

// ---- pkg/wdt_consts.svh ----
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// register byte offsets
`define WDT_OFS_CTRL 8'h00
`define WDT_OFS_CODE 8'h04
`define WDT_OFS_STAT 8'h08
`define WDT_OFS_ISTAT 8'h0c
`define WDT_OFS_IMASK 8'h10
`define WDT_OFS_NONE 8'hff

// control field positions
`define WDT_BIT_OVF_SEL 0
`define WDT_PSEL_LO 1
`define WDT_PSEL_HI 2
`define WDT_BIT_EN 3
`define WDT_BIT_PRESC 4

// reset values
`define WDT_PSEL_RST 2'h0
`define WDT_PRESC_RST 1'h0
`define WDT_OVF_SEL_RST 1'h1

// code port values
`define WDT_CODE_CLEAR 8'h4e
`define WDT_CODE_DISABLE 8'hb1

// bus constants
`define WDT_HSIZE_WORD 3'h2

// timing: divider stage exponent, one quarter of the longest unprescaled period 2^25/fc
`define WDT_DIV_EXP 23
`define WDT_DIV_W 25
`define WDT_RST_TIME_FC 24
`define WDT_FC_PERIOD_PS 8000
`define WDT_MCLK_PERIOD_PS 8000
`define WDT_RST_CYCLES ((`WDT_RST_TIME_FC * `WDT_FC_PERIOD_PS) / `WDT_MCLK_PERIOD_PS)

`endif

// ---- pkg/wdt_pkg.sv ----
package wdt_pkg;

  // watchdog run state, gray coded along run -> armed -> off
  typedef enum logic [1:0]
  {
    WDT_RUN = 2'h0,
    WDT_ARMED = 2'h1,
    WDT_OFF = 2'h3
  } wdt_state_t;

endpackage

// ---- hdl/wdt_divider.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_divider
#(
  parameter int DIV_EXP = `WDT_DIV_EXP
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // period selection
  input wire logic [1:0] period_select,
  input wire logic prescaler_select,
  // stage tick, one pulse per quarter period
  output logic tick
);

  logic [`WDT_DIV_W-1:0] div;
  logic [`WDT_DIV_W-1:0] next_div;
  logic [`WDT_DIV_W-1:0] mask;
  logic next_tick;

  // stage length: each period code quarters, prescaler doubles
  always_comb
  begin
    int k;
    k = DIV_EXP - 2 * int'(period_select) + int'(prescaler_select);
    for (int i = 0; i < `WDT_DIV_W; i++)
    begin
      mask[i] = (i < k);
    end
  end

  // free running, never touched by the clear code
  always_comb
  begin
    next_div = div + {{(`WDT_DIV_W-1){1'b0}}, 1'b1};
    next_tick = &(div | ~mask);
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      div <= '0;
      tick <= 1'b0;
    end
    else
    begin
      div <= next_div;
      tick <= next_tick;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_tick_on_wrap: assert property (tick && $stable(mask) |-> (div & mask) == '0)
    else $error("divider tick not at stage wrap");

endmodule // wdt_divider
`default_nettype wire

// ---- hdl/wdt_rst_stretch.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_rst_stretch
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // request and stretched reset
  input wire logic start,
  output logic rst_out
);

  localparam logic [4:0] RST_LEN = 5'(`WDT_RST_CYCLES);

  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic next_rst_out;

  // fixed length pulse, a start while busy is ignored
  always_comb
  begin
    next_cnt = cnt;
    if (cnt != 5'h0)
    begin
      next_cnt = cnt - 5'h1;
    end
    else if (start)
    begin
      next_cnt = RST_LEN;
    end
    next_rst_out = (next_cnt != 5'h0);
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cnt <= 5'h0;
      rst_out <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      rst_out <= next_rst_out;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_rst_length: assert property ($rose(rst_out) |-> ##23 rst_out ##1 !rst_out)
    else $error("watchdog reset not 24 cycles long");

endmodule // wdt_rst_stretch
`default_nettype wire

// ---- dv/wdt_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_cpu_model
(
  // clock
  input wire logic mclk,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // raised when a transfer never completes
  output logic hung
);
  // bus idle from time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    hung = 1'b0;
  end

  // one single word transfer: address phase held until hready, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= `WDT_HSIZE_WORD;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    q = hrdata;
    if (n >= 64)
      hung <= 1'b1;
  endtask

  // stack is set up before interrupt mode is chosen; the model has no stack to set
  task automatic irq_mode(input logic [31:0] ctl_val);
    logic [31:0] q;
    xfer(1'b1, `WDT_OFS_CTRL, ctl_val, q);
  endtask

  // handler service: the clear code retires the pending timeout before any return
  task automatic service();
    logic [31:0] q;
    xfer(1'b1, `WDT_OFS_CODE, `WDT_CODE_CLEAR, q);
  endtask

  // guarded shutdown; interrupts are taken as already off on this side
  task automatic shut_down(input logic [31:0] ctl_off);
    logic [31:0] q;
    service();
    xfer(1'b1, `WDT_OFS_CTRL, ctl_off, q);
    xfer(1'b1, `WDT_OFS_CODE, `WDT_CODE_DISABLE, q);
  endtask
endmodule // wdt_cpu_model
`default_nettype wire

// ---- dv/watchdog_timer_core_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.svh"
module watchdog_timer_core_tb_top;
  localparam int DIV = 8;
  logic mclk, nrst, hsel, hwrite, hready, hresp, tmo, pend, rreq, irq, hung;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int errors = 0;
  int check_count = 0;
  int seen = 0;
  int n, s0;

  // design and bus master
  wdt_core #(.DIV_EXP(DIV)) i_dut
  (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .timeout_interrupt(tmo), .nmi_pending(pend), .wdt_reset_req(rreq), .irq(irq)
  );
  wdt_cpu_model i_cpu
  (
    .mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hung(hung)
  );

  // 125 mhz clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // count timeout pulses
  always @(posedge mclk)
    if (tmo === 1'b1)
      seen <= seen + 1;

  // a hung bus ends the run
  always @(posedge hung)
  begin
    errors++;
    complete_run();
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_cpu.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    i_cpu.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  // cycles until the chosen output is sampled high; bounded
  task automatic wait_ev(input bit rst_side, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge mclk);
      cyc++;
    end
    while ((rst_side ? rreq : tmo) !== 1'b1 && cyc < 5000);
    if (cyc >= 5000)
    begin
      errors++;
      complete_run();
    end
  endtask

  // control word from its fields
  function automatic logic [31:0] ctl(input logic ovf, input logic [1:0] p, input logic ps, input logic en);
    ctl = 32'h0;
    ctl[`WDT_BIT_OVF_SEL] = ovf;
    ctl[`WDT_PSEL_HI:`WDT_PSEL_LO] = p;
    ctl[`WDT_BIT_EN] = en;
    ctl[`WDT_BIT_PRESC] = ps;
  endfunction

  // overflow period in clock cycles
  function automatic int period(input int p, input int ps);
    return 4 << (DIV - 2 * p + ps);
  endfunction

  // code stream: clear codes, or random non-clear codes with a disable code first
  task automatic feed(input bit clr);
    logic [7:0] code;
    for (int i = 0; i < 12; i++)
    begin
      code = 8'($urandom_range(255));
      if (code == `WDT_CODE_CLEAR)
        code = 8'h4f;
      if (i == 0)
        code = `WDT_CODE_DISABLE;
      wr(`WDT_OFS_CODE, clr ? 32'(`WDT_CODE_CLEAR) : 32'(code));
      repeat (150) @(posedge mclk);
    end
  endtask

  initial
  begin
    nrst = 1'b0;
    void'($urandom(32'he5ec));
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // enabled out of reset, write-only places read nothing
    rd(`WDT_OFS_STAT, 32'h3);
    rd(`WDT_OFS_CTRL, 32'h0);
    rd(`WDT_OFS_CODE, 32'h0);
    rd(32'h100, 32'h0);
    // reset-request overflow and its length
    wr(`WDT_OFS_IMASK, 32'h3);
    wr(`WDT_OFS_CTRL, ctl(1'b1, 2'h3, 1'b0, 1'b1));
    wait_ev(1'b1, n);
    n = 0;
    while (rreq === 1'b1 && n < 99)
    begin
      @(posedge mclk);
      n++;
    end
    check(n, `WDT_RST_CYCLES);
    rd(`WDT_OFS_ISTAT, 32'h2);
    check(32'(irq), 32'h1);
    wr(`WDT_OFS_ISTAT, 32'h2);
    rd(`WDT_OFS_ISTAT, 32'h0);
    // every period code, masked: timeout still arrives
    wr(`WDT_OFS_IMASK, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      i_cpu.irq_mode(ctl(1'b0, c[1:0], c[2], 1'b1));
      wait_ev(1'b0, n);
      wait_ev(1'b0, n);
      check(n, period(c % 4, c / 4));
    end
    check(32'(pend), 32'h1);
    check(32'(irq), 32'h0);
    // clear code after a random delay: next overflow in three to four stages
    i_cpu.irq_mode(ctl(1'b0, 2'h1, 1'b0, 1'b1));
    for (int i = 0; i < 4; i++)
    begin
      wait_ev(1'b0, n);
      repeat ($urandom_range(200)) @(posedge mclk);
      i_cpu.service();
      // the clear lands at the edge the write ends on; look one edge later
      @(posedge mclk);
      check(32'(pend), 32'h0);
      wait_ev(1'b0, n);
      check(32'(n >= 192 && n <= 256), 32'h1);
    end
    // let the pulse counter take the last detected timeout first
    @(posedge mclk);
    s0 = seen;
    feed(1'b1);
    check(seen - s0, 0);
    s0 = seen;
    feed(1'b0);
    check(32'(seen - s0 >= 6), 32'h1);
    // guarded shutdown keeps the counter at zero
    i_cpu.shut_down(ctl(1'b0, 2'h3, 1'b0, 1'b0));
    s0 = seen;
    rd(`WDT_OFS_STAT, 32'h0);
    repeat (600) @(posedge mclk);
    check(seen - s0, 0);
    rd(`WDT_OFS_STAT, 32'h0);
    // interrupt raise, mask, clear
    check(32'(irq), 32'h0);
    wr(`WDT_OFS_IMASK, 32'h1);
    rd(`WDT_OFS_IMASK, 32'h1);
    check(32'(irq), 32'h1);
    wr(`WDT_OFS_ISTAT, 32'h1);
    rd(`WDT_OFS_ISTAT, 32'h0);
    check(32'(irq), 32'h0);
    // enable again: overflow within four short stages
    wr(`WDT_OFS_CTRL, ctl(1'b0, 2'h3, 1'b0, 1'b1));
    wait_ev(1'b0, n);
    check(32'(n <= 20), 32'h1);
    check(32'(hresp), 32'h0);
    complete_run();
  end
endmodule // watchdog_timer_core_tb_top
`default_nettype wire
